/* File: smsm_mcu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module smsm_mcu_model
(
  input wire logic clk_sys, // system clock
  input wire logic mcuResetN, // reset from the device
  output logic spiCsN, // chip select, low active
  output logic spiSck, // serial clock, parked low
  output logic spiMosi // serial data
);
  // bus idle: deselected, clock still
  initial
  begin
    spiCsN = 1'b1;
    spiSck = 1'b0;
    spiMosi = 1'b0;
  end
  // step off the edge so the device samples settled pins
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // master sends one 16-bit frame msb first, data moves while sck is low
  task automatic sendWord(input logic [15:0] w);
    int i;
    begin
      wait (mcuResetN === 1'b1); // a controller in reset sends nothing
      tick(1);
      spiCsN = 1'b0;
      for (i = 15; i >= 0; i--)
      begin
        spiMosi = w[i];
        tick(4);
        spiSck = 1'b1;
        tick(4);
        spiSck = 1'b0;
      end
      tick(2);
      spiCsN = 1'b1;
      spiMosi = ~w[0]; // released line must not show a stale bit
      tick(8); // gap covers the answer latency and the minimum high time
    end
  endtask : sendWord
endmodule : smsm_mcu_model
`default_nettype wire

/* File: smsm_mode_fsm.sv */
// Behaviour
// - init at power-up and after soft reset
// - stop mode keeps main regulator on
// - sleep mode switches main regulator off
// - wake in sleep/failsafe or failure gives restart
// - restart holds microcontroller in reset
// - failure gone, reset delay, then normal
// - critical failure: failsafe, main regulator off
// - failsafe until wake or overtemperature clears
// - test pin high in init: development mode
// - development stops watchdog, all modes reachable
// - development forces CAN normal, auxiliary on
// - control over 16-bit serial frames
// - mode field write selects operating mode
// - restart clears the mode field
// - code 11 is soft reset to init
// - any frame in init gives normal
// - wakes ignored during init
`timescale 1ns/1ns
`default_nettype none
module smsm_mode_fsm
  import smsm_pkg::*;
#(
  parameter int RESET_DELAY = RESET_DELAY_CYC // restart hold in cycles
)
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // power-on reset, low active
  input wire logic spiCsN, // serial chip select pin, low active
  input wire logic spiSck, // serial clock pin
  input wire logic spiMosi, // serial data pin
  input wire logic testPin, // test strap pin
  input wire logic wakeCan, // CAN wake event
  input wire logic wakeHv, // high_voltage_wake_input event
  input wire logic wakeGpio, // wake-configured GPIO event
  input wire logic wdFail, // watchdog failure
  input wire logic mainUv, // main regulator undervoltage reset
  input wire logic overTemp, // overtemperature present
  input wire logic failSafeCfg, // failure in normal or stop goes to failsafe, not restart
  output logic mcuResetN, // reset to the microcontroller, low active
  output logic mainRegEn, // main_regulator_output enable
  output logic auxRegEn, // auxiliary_regulator_output enable
  output logic canNormal, // force CAN transceiver normal
  output logic wdRun, // watchdog counter enable
  output logic devMode, // development mode selected
  output logic softReset, // pulse: load soft-reset register values
  output logic [2:0] modeState, // current operating mode
  output logic [1:0] modeField // mode field as read back
);

  // synchronised pin levels
  // chip select is synced in its active sense: the sync flops reset to 0, which then
  // reads as deselected, so no false frame end follows a reset release
  logic csSel; // synced chip select, high while selected
  logic sckS;
  logic mosiS;
  logic testS;
  logic frameDone;
  logic frameValid;
  logic [FRAME_BITS-1:0] frameWord;

  // every pin passes two flops before use; the frame receiver and the
  // strap logic only ever see the second stage
  // chip select, inverted on the way in
  smsm_sync uCs (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(!spiCsN),
    .pinOut(csSel)
  );

  // serial clock, parked low between frames
  smsm_sync uSck (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(spiSck),
    .pinOut(sckS)
  );

  // serial data, only looked at on a rising serial clock
  smsm_sync uMosi (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(spiMosi),
    .pinOut(mosiS)
  );

  // test strap; its level only matters while in init
  smsm_sync uTest (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(testPin),
    .pinOut(testS)
  );

  // frame receiver; it only reports frames, the decode of what a frame
  // asks for stays here with the mode logic
  smsm_spi_rx #(
    .FRAME_W(FRAME_BITS)
  ) uRx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .csN(!csSel),
    .sck(sckS),
    .mosi(mosiS),
    .frameDone(frameDone),
    .frameValid(frameValid),
    .frameWord(frameWord)
  );

  // whole state of the controller
  typedef struct packed {
    smsm_mode_t mode;
    logic [1:0] field;
    logic dev;
    logic [31:0] dly;
    logic srst;
    logic rstN;
    logic mainEn;
    logic auxEn;
    logic canN;
    logic wd;
  } smsm_state_t;

  smsm_state_t st_r;
  smsm_state_t st_nxt;

  // decoded request and events
  logic wrBit; // frame asks for a write
  logic addrHit; // frame targets the mode-control register
  logic ctrlWrite; // accepted mode-control write, one cycle
  logic [1:0] reqCode; // requested mode code
  logic wakeAny; // any wake source this cycle
  logic failAny; // any failure that forces a reset

  // a control write is a complete write frame to the mode-control address;
  // frames of any other length are dropped so, outside init, a torn frame cannot change mode
  always_comb
  begin
    wrBit = frameWord[FRAME_BITS-1];
    addrHit = (frameWord[CTRL_ADDR_POS+3:CTRL_ADDR_POS] == CTRL_ADDR);
    ctrlWrite = frameDone && frameValid && wrBit && addrHit;
    reqCode = frameWord[MODE_FIELD_POS+1:MODE_FIELD_POS];
    // wakes are plain events, the sources are already in this clock
    wakeAny = wakeCan || wakeHv || wakeGpio;
    // both failures are handled alike here
    failAny = wdFail || mainUv;
  end

  // mode sequencing; one pass per clock, the next state decides every output
  // below so the outputs never lag the mode by a cycle
  always_comb
  begin
    // hold everything unless a branch says otherwise
    st_nxt = st_r;
    // soft reset is a pulse, so it drops by default
    st_nxt.srst = 1'b0;
    case (st_r.mode)
      MODE_INIT:
      begin
        // strap caught while in init, after reset release
        st_nxt.dev = testS;
        // wakes are not looked at here
        if (failAny)
        begin
          // a missed start-up still resets the controller
          st_nxt.mode = MODE_RESTART;
        end
        else if (frameDone)
        begin
          // any frame counts, even a torn or illegal one
          st_nxt.mode = MODE_NORMAL;
        end
      end

      MODE_NORMAL, MODE_STOP:
      begin
        if (failAny)
        begin
          // configuration picks failsafe over restart
          st_nxt.mode = failSafeCfg ? MODE_FAILSAFE : MODE_RESTART;
        end
        else if (ctrlWrite)
        begin
          case (reqCode)
            MFIELD_NORMAL:
            begin
              st_nxt.mode = MODE_NORMAL;
            end
            MFIELD_STOP:
            begin
              // main regulator stays up, see the output logic
              st_nxt.mode = MODE_STOP;
            end
            MFIELD_SLEEP:
            begin
              // controller loses its supply from the next cycle
              st_nxt.mode = MODE_SLEEP;
            end
            default:
            begin
              // soft reset: back to init, registers to their reset values
              st_nxt.mode = MODE_INIT;
            end
          endcase
          // the soft-reset code is never kept; the field reads back as reset
          st_nxt.field = (reqCode == MFIELD_SOFTRST) ? MFIELD_RESET_VAL : reqCode;
          st_nxt.srst = (reqCode == MFIELD_SOFTRST);
        end
      end

      MODE_SLEEP:
      begin
        // failures wait for a wake here; the controller is unpowered anyway
        if (wakeAny)
        begin
          st_nxt.mode = MODE_RESTART;
        end
      end

      MODE_FAILSAFE:
      begin
        // permanent until a wake or the heat is gone
        if (wakeAny || !overTemp)
        begin
          st_nxt.mode = MODE_RESTART;
        end
      end

      MODE_RESTART:
      begin
        // the field tracks the mode, so passing here wipes the last request
        st_nxt.field = MFIELD_RESET_VAL;
        // the delay only runs once the cause has gone
        if (failAny)
        begin
          st_nxt.dly = '0;
        end
        else if (st_r.dly >= 32'(RESET_DELAY - 1))
        begin
          st_nxt.mode = MODE_NORMAL;
          st_nxt.dly = '0;
        end
        else
        begin
          // still counting the hold time
          st_nxt.dly = st_r.dly + 32'h1;
        end
      end

      default:
      begin
        // unused codes fall back to a clean start
        st_nxt.mode = MODE_INIT;
      end
    endcase
    // outputs follow the next mode so they leave a flop
    // controller reset is held for the whole restart stay
    st_nxt.rstN = (st_nxt.mode != MODE_RESTART);
    // main regulator is off only in the two unpowered modes; stop keeps it
    st_nxt.mainEn = !(st_nxt.mode == MODE_SLEEP || st_nxt.mode == MODE_FAILSAFE);
    // development mode keeps the debug path alive in every mode
    st_nxt.auxEn = st_nxt.dev;
    st_nxt.canN = st_nxt.dev;
    // the watchdog is only stopped, its own settings are left alone
    st_nxt.wd = !st_nxt.dev;
  end

  // state register; power-up lands in init
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // power-up state: init, controller out of reset, main regulator on
      st_r <= '{mode: MODE_INIT,
                field: MFIELD_RESET_VAL,
                dev: 1'b0,
                dly: '0,
                srst: 1'b0,
                rstN: 1'b1,
                mainEn: 1'b1,
                auxEn: 1'b0,
                canN: 1'b0,
                wd: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // every output is a plain copy of a state flop
  assign mcuResetN = st_r.rstN;
  assign mainRegEn = st_r.mainEn;
  assign auxRegEn = st_r.auxEn;
  assign canNormal = st_r.canN;
  assign wdRun = st_r.wd;
  // status seen by the read-back side
  assign devMode = st_r.dev;
  assign softReset = st_r.srst;
  assign modeState = st_r.mode;
  assign modeField = st_r.field;

endmodule : smsm_mode_fsm
`default_nettype wire

/* File: smsm_mode_fsm_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module smsm_mode_fsm_chk
  import smsm_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, low active
  input wire logic wakeCan, // can wake event
  input wire logic wakeHv, // high voltage wake event
  input wire logic wakeGpio, // gpio wake event
  input wire logic wdFail, // watchdog failure
  input wire logic mainUv, // undervoltage reset
  input wire logic mcuResetN, // reset to controller
  input wire logic mainRegEn, // main regulator enable
  input wire logic auxRegEn, // auxiliary regulator enable
  input wire logic canNormal, // can forced normal
  input wire logic wdRun, // watchdog counter enable
  input wire logic devMode, // development flag
  input wire logic softReset, // soft reset pulse
  input wire logic [2:0] modeState, // current mode
  input wire logic [1:0] modeField // mode field read back
);
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_stop_reg_on: assert property (modeState == MODE_STOP |-> mainRegEn)
    else $error("main regulator off in stop");
  a_sleep_reg_off: assert property (modeState == MODE_SLEEP |-> !mainRegEn)
    else $error("main regulator on in sleep");
  a_failsafe_reg_off: assert property (modeState == MODE_FAILSAFE |-> !mainRegEn)
    else $error("main regulator on in failsafe");
  a_restart_holds_reset: assert property (modeState == MODE_RESTART |-> !mcuResetN)
    else $error("controller not held in reset");
  // field may lag entry by one cycle, so judge from the second cycle on
  a_restart_clears_field: assert property (modeState == MODE_RESTART
    && $past(modeState) == MODE_RESTART |-> modeField == MFIELD_RESET_VAL)
    else $error("mode field not cleared in restart");
  a_restart_exit_normal: assert property ($fell(modeState == MODE_RESTART)
    |-> modeState == MODE_NORMAL)
    else $error("restart left to a mode other than normal");
  a_init_wake_ignored: assert property (modeState == MODE_INIT
    && (wakeCan || wakeHv || wakeGpio) && !wdFail && !mainUv |=> modeState != MODE_RESTART)
    else $error("wake acted during init");
  a_dev_outputs: assert property (devMode && $past(devMode)
    |-> !wdRun && canNormal && auxRegEn)
    else $error("development outputs wrong");
  a_soft_to_init: assert property (softReset
    |-> ##[0:1] (modeState == MODE_INIT && modeField == MFIELD_RESET_VAL))
    else $error("soft reset did not give init");
  a_soft_one_cycle: assert property (softReset |=> !softReset)
    else $error("soft reset pulse too long");
endmodule : smsm_mode_fsm_chk
bind smsm_mode_fsm smsm_mode_fsm_chk smsm_mode_fsm_chk_i (.clk_sys, .rst_n, .wakeCan,
  .wakeHv, .wakeGpio, .wdFail, .mainUv, .mcuResetN, .mainRegEn, .auxRegEn, .canNormal,
  .wdRun, .devMode, .softReset, .modeState, .modeField);
`default_nettype wire

/* File: smsm_pkg.sv */
`default_nettype none
package smsm_pkg;

  // operating modes of the supervisor
  typedef enum logic [2:0] {
    MODE_INIT     = 3'b000,
    MODE_NORMAL   = 3'b001,
    MODE_STOP     = 3'b010,
    MODE_SLEEP    = 3'b011,
    MODE_RESTART  = 3'b100,
    MODE_FAILSAFE = 3'b101
  } smsm_mode_t;

  // serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int FRAME_WIDE_BITS = 32;
  localparam int MODE_FIELD_POS = 6;
  localparam logic [3:0] CTRL_ADDR = 4'h1;
  localparam int CTRL_ADDR_POS = 8;

  // mode field codes
  localparam logic [1:0] MFIELD_NORMAL = 2'h0;
  localparam logic [1:0] MFIELD_SLEEP = 2'h1;
  localparam logic [1:0] MFIELD_STOP = 2'h2;
  localparam logic [1:0] MFIELD_SOFTRST = 2'h3;
  localparam logic [1:0] MFIELD_RESET_VAL = 2'h0;

  // reset delay time
  localparam int CLK_MHZ = 125;
  localparam int RESET_DELAY_US = 10;
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * CLK_MHZ;

endpackage : smsm_pkg
`default_nettype wire

/* File: smsm_spi_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module smsm_spi_rx
  import smsm_pkg::*;
#(
  parameter int FRAME_W = FRAME_BITS // short frame length
)
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset
  input wire logic csN, // synced chip select, low active
  input wire logic sck, // synced serial clock
  input wire logic mosi, // synced data in
  output logic frameDone, // pulse at end of a frame
  output logic frameValid, // frame was 16 or 32 bits
  output logic [FRAME_W-1:0] frameWord // first 16 bits received
);

  // receiver state
  typedef struct packed {
    logic sckD;
    logic csD;
    logic [5:0] cnt;
    logic [FRAME_W-1:0] sh;
    logic done;
    logic valid;
    logic [FRAME_W-1:0] word;
  } smsm_rx_t;

  smsm_rx_t st_r;
  smsm_rx_t st_nxt;

  // sample on rising sck, close frame on cs release
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sckD = sck;
    st_nxt.csD = csN;
    st_nxt.done = 1'b0;
    if (!csN && sck && !st_r.sckD)
    begin
      // only the first word is kept; a 32-bit frame carries two
      if (st_r.cnt < 6'(FRAME_W))
      begin
        st_nxt.sh = {st_r.sh[FRAME_W-2:0], mosi};
      end
      if (st_r.cnt != 6'h3f)
      begin
        st_nxt.cnt = st_r.cnt + 6'h01;
      end
    end
    if (csN && !st_r.csD)
    begin
      st_nxt.done = 1'b1;
      st_nxt.valid = (st_r.cnt == 6'(FRAME_W)) || (st_r.cnt == 6'(FRAME_WIDE_BITS));
      st_nxt.word = st_r.sh;
      st_nxt.cnt = 6'h00;
    end
  end

  // register receiver
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '{sckD: 1'b0, csD: 1'b1, cnt: 6'h00, sh: '0, done: 1'b0, valid: 1'b0,
                word: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign frameDone = st_r.done;
  assign frameValid = st_r.valid;
  assign frameWord = st_r.word;

endmodule : smsm_spi_rx
`default_nettype wire

/* File: smsm_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module smsm_sync
  import smsm_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset
  input wire logic pinIn, // raw pin
  output logic pinOut // synchronised level
);

  // two-stage state, stage 0 only read by stage 1
  typedef struct packed {
    logic s0;
    logic s1;
  } smsm_sync_t;

  smsm_sync_t st_r;
  smsm_sync_t st_nxt;

  // shift the pin along
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s0 = pinIn;
    st_nxt.s1 = st_r.s0;
  end

  // register stages
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pinOut = st_r.s1;

endmodule : smsm_sync
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import smsm_pkg::*;
  localparam int RDLY = 8; // shortened restart hold
  logic clk_sys, rst_n, testPin, wakeCan, wakeHv, wakeGpio; // driven inputs
  logic wdFail, mainUv, overTemp, failSafeCfg; // failure inputs
  logic spiCsN, spiSck, spiMosi; // serial pins from the model
  logic mcuResetN, mainRegEn, auxRegEn, canNormal, wdRun, devMode, softReset; // outputs
  logic [2:0] modeState; // current mode
  logic [1:0] modeField; // mode field
  int errors = 0; // mismatches
  int n_compared = 0; // comparisons
  smsm_mode_fsm #(.RESET_DELAY(RDLY)) smsm_mode_fsm_i (.clk_sys, .rst_n, .spiCsN, .spiSck,
    .spiMosi, .testPin, .wakeCan, .wakeHv, .wakeGpio, .wdFail, .mainUv, .overTemp,
    .failSafeCfg, .mcuResetN, .mainRegEn, .auxRegEn, .canNormal, .wdRun, .devMode,
    .softReset, .modeState, .modeField);
  smsm_mcu_model smsm_mcu_model_i (.clk_sys, .mcuResetN, .spiCsN, .spiSck, .spiMosi);
  // 125 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // bounded wait for a mode, then judge it
  task automatic waitMode(input logic [2:0] m, input int lim);
    int i;
    for (i = 0; i < lim && modeState !== m; i++)
      tick(1);
    check("modeState", {5'h0, modeState}, {5'h0, m});
  endtask : waitMode
  task automatic pulseWake(input logic [2:0] w);
    wakeCan = w[2];
    wakeHv = w[1];
    wakeGpio = w[0];
    tick(1);
    wakeCan = 1'b0;
    wakeHv = 1'b0;
    wakeGpio = 1'b0;
  endtask : pulseWake
  // failure and configuration levels, all four at once
  task automatic setFail(input logic wd, input logic uv, input logic ot, input logic cfg);
    wdFail = wd;
    mainUv = uv;
    overTemp = ot;
    failSafeCfg = cfg;
  endtask : setFail
  task automatic t_init();
    check("resetOuts", {1'b0, mcuResetN, mainRegEn, auxRegEn, canNormal, wdRun, devMode,
      softReset}, 8'h64);
    pulseWake(3'h7);
    tick(4);
    waitMode(MODE_INIT, 1);
    smsm_mcu_model_i.sendWord(16'h0000); // illegal frame still leaves init
    waitMode(MODE_NORMAL, 4);
    $display("test init done");
  endtask : t_init
  task automatic t_modes();
    smsm_mcu_model_i.sendWord(16'h8180);
    waitMode(MODE_STOP, 4);
    check("stopReg", {7'h0, mainRegEn}, 8'h01);
    check("stopField", {6'h0, modeField}, {6'h0, MFIELD_STOP});
    smsm_mcu_model_i.sendWord(16'h8100);
    waitMode(MODE_NORMAL, 4);
    smsm_mcu_model_i.sendWord(16'h8140);
    waitMode(MODE_SLEEP, 4);
    check("sleepReg", {7'h0, mainRegEn}, 8'h00);
    smsm_mcu_model_i.sendWord(16'h8100); // sleep refuses frames
    waitMode(MODE_SLEEP, 1);
    pulseWake(3'h4);
    waitMode(MODE_RESTART, 8);
    tick(1);
    check("rstHold", {5'h0, mcuResetN, modeField}, 8'h00);
    waitMode(MODE_NORMAL, RDLY + 4);
    $display("test modes done");
  endtask : t_modes
  task automatic t_fail();
    setFail(1'b1, 1'b0, 1'b0, 1'b0);
    waitMode(MODE_RESTART, 8);
    tick(3 * RDLY);
    waitMode(MODE_RESTART, 1);
    setFail(1'b0, 1'b0, 1'b0, 1'b0);
    waitMode(MODE_NORMAL, RDLY + 4);
    setFail(1'b0, 1'b1, 1'b1, 1'b1);
    tick(1);
    setFail(1'b0, 1'b0, 1'b1, 1'b1);
    waitMode(MODE_FAILSAFE, 8);
    check("fsReg", {7'h0, mainRegEn}, 8'h00);
    tick(30);
    waitMode(MODE_FAILSAFE, 1);
    pulseWake(3'h2);
    waitMode(MODE_NORMAL, RDLY + 12);
    setFail(1'b1, 1'b0, 1'b1, 1'b1);
    tick(1);
    setFail(1'b0, 1'b0, 1'b1, 1'b1);
    waitMode(MODE_FAILSAFE, 8);
    setFail(1'b0, 1'b0, 1'b0, 1'b1);
    waitMode(MODE_NORMAL, RDLY + 12);
    setFail(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test fail done");
  endtask : t_fail
  task automatic t_soft();
    logic seen;
    int i;
    seen = 1'b0;
    // watch for the one-cycle pulse while the frame goes out
    fork
      smsm_mcu_model_i.sendWord(16'h81c0);
      for (i = 0; i < 200 && !seen; i++)
      begin
        tick(1);
        if (softReset === 1'b1)
          seen = 1'b1;
      end
    join
    check("softSeen", {7'h0, seen}, 8'h01);
    waitMode(MODE_INIT, 4);
    check("softField", {6'h0, modeField}, {6'h0, MFIELD_RESET_VAL});
    check("softPulse", {7'h0, softReset}, 8'h00);
    $display("test soft done");
  endtask : t_soft
  task automatic t_dev();
    rst_n = 1'b0;
    tick(1);
    rst_n = 1'b1;
    testPin = 1'b1;
    tick(8);
    check("devOuts", {4'h0, devMode, wdRun, canNormal, auxRegEn}, 8'h0b);
    smsm_mcu_model_i.sendWord(16'h0000);
    smsm_mcu_model_i.sendWord(16'h8180);
    waitMode(MODE_STOP, 4);
    check("devStop", {5'h0, wdRun, canNormal, mainRegEn}, 8'h03);
    $display("test dev done");
  endtask : t_dev
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // main sequence: reset for 8 cycles, then the scenarios
  initial
  begin
    rst_n = 1'b0;
    testPin = 1'b0;
    wakeCan = 1'b0;
    wakeHv = 1'b0;
    wakeGpio = 1'b0;
    setFail(1'b0, 1'b0, 1'b0, 1'b0);
    tick(8);
    rst_n = 1'b1;
    t_init();
    t_modes();
    t_fail();
    t_soft();
    t_dev();
    tally_and_finish();
  end
  // hang guard, well beyond the roughly 1230 cycles the run needs
  initial
  begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
